// [verilog/rbws_pkg.sv]
`default_nettype none
package rbws_pkg;

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_RESET,
		ST_BOOT,
		ST_RUN,
		ST_IDLE,
		ST_QUAL,
		ST_RESUME
	} rbws_state_e;

	// Counts in cycles of the input clock.
	localparam logic [9:0] WD_RESET_CYC = 10'h200;
	localparam logic [5:0] EXT_VALID_CYC = 6'h20;

	// Counts in cycles of the system clock.
	localparam logic [11:0] BOOT_SYS_CYC = 12'h4ec;
	localparam logic [11:0] RESUME_ACTIVE_CYC = 12'h008;
	localparam logic [11:0] RESUME_SLEEP_CYC = 12'h41a;
	localparam logic [11:0] QUAL_MUL = 12'h005;
	localparam logic [11:0] QUAL_FACTOR = 12'h002;

	// Width of the boot-mode strap group.
	localparam int unsigned BOOT_W = 4;

	// Register byte offsets.
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_EXTCFG = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;

	// Control register field positions.
	localparam int unsigned CTRL_IDLE_BIT = 0;
	localparam int unsigned CTRL_QUALEN_BIT = 1;
	localparam int unsigned CTRL_FLASHSLP_BIT = 2;
	localparam int unsigned CTRL_QUALIFIER_PERIOD_LSB = 8;

	// Clock-divide register field positions and reset value.
	localparam int unsigned EXTCFG_TIMDIV_BIT = 0;
	localparam int unsigned EXTCFG_OUTDIV_BIT = 1;
	localparam logic EXTCFG_DIV_RST = 1'b1;

	// Whole state of the sequencer.
	typedef struct packed {
		rbws_state_e st;
		logic phase;
		logic [11:0] seqCnt;
		logic [5:0] exCnt;
		logic [9:0] wdCnt;
		logic pllOff;
		logic memMap;
		logic extValid;
		logic bootDone;
		logic bootPulse;
		logic resumePulse;
		logic [BOOT_W-1:0] bootMode;
		logic qualEn;
		logic flashSleep;
		logic [7:0] qualifier_period;
		logic timDiv;
		logic outDiv;
		logic clkOut;
		logic [1:0] clkCnt;
		logic ack;
		logic [31:0] rdata;
	} rbws_regs_s;

	// Value after reset.
	localparam rbws_regs_s RBWS_RST = '{st: ST_RESET, timDiv: EXTCFG_DIV_RST, outDiv: EXTCFG_DIV_RST, default: '0};

endpackage
`default_nettype wire

// [verilog/rbws_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module rbws_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Asynchronous input and its synchronised copy.
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// Two flip-flops; only the second stage is visible outside.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= asyncIn;
			sync_r <= meta_r;
		end
	end

	assign syncOut = sync_r;

endmodule // rbws_sync
`default_nettype wire

// [verilog/rbws_sequencer.sv]
// Notes on behaviour
// R1: A watchdog trigger drives the reset line low for 512 input-clock cycles.
// R2: The outside party holds reset low at least 8 input-clock cycles.
// R3: The outside party gives a stable clock 8 cycles before releasing reset.
// R4: External address and data are valid 32 input-clock cycles after release.
// R5: The PLL-disable strap is stable 16 cycles around reset release.
// R6: The memory-map strap is stable 16 cycles after reset release.
// R7: Boot-mode straps hold their levels 2520 input-clock cycles after release.
// R8: Boot code runs 1260 system cycles, then boot-mode pins are sampled.
// R9: Both clock-divide bits reset to one, dividing the output clock by four.
// R10: Wake pulses last 2 cycles, or 1 plus qualification time.
// R11: Qualification time is 5 times qualifier period times 2 system cycles.
// R12: Resume with flash active or from RAM takes 8 system cycles.
// R13: Resume with flash asleep takes 1050 system cycles.
// R14: Enabled interrupt, watchdog interrupt, NMI pin or reset wake from IDLE.
// R15: Resume marks the instruction after IDLE; interrupt service adds latency.
// R16: A low PLL-disable strap at reset clocks the core straight from input.
// R17: Delay counters are synchronous and start on synchronised trigger edges.
// R18: Reset input is synchronised and restarts all counters when reasserted; the code restarts seqCnt and exCnt but not wdCnt or clkCnt.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module rbws_sequencer (
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Avalon-MM slave.
	input wire logic [3:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [3:0] avsByteenable,
	input wire logic [31:0] avsWritedata,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	// Reset pin, open drain.
	input wire logic resetInN,
	output logic resetOut,
	output logic resetOe,
	// Strap pins.
	input wire logic pllDisableStrap,
	input wire logic memoryMapSelectStrap,
	input wire logic [rbws_pkg::BOOT_W-1:0] bootModePins,
	// Wake sources.
	input wire logic wakeIrq,
	input wire logic watchdogInterrupt,
	input wire logic nonmaskableInterruptPinN,
	// Watchdog expiry, one-cycle pulse from logic on this clock.
	input wire logic watchdogTrigger,
	// Sequencer outputs.
	output logic coreClockDirect,
	output logic memoryMapSelect,
	output logic extBusValid,
	output logic bootSample,
	output logic [rbws_pkg::BOOT_W-1:0] bootMode,
	output logic bootDone,
	output logic idleActive,
	output logic idleResume,
	output logic clockOutPin
);
	import rbws_pkg::*;

	rbws_regs_s s_r;
	rbws_regs_s s_nxt;
	logic rstInS;
	logic pllS;
	logic mmS;
	logic nmiNS;
	logic wakeIrqS;
	logic wdIntS;
	logic [BOOT_W-1:0] bootS;
	logic sysEn;
	logic wakeAny;
	logic busReq;
	logic wrDone;
	logic [11:0] qualTarget;
	logic [11:0] resumeTarget;
	logic [1:0] halfLimit;

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for every pin input.

	rbws_sync #(.W(1), .RST_VAL(1'b0)) uSyncRst (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn(resetInN),
		.syncOut(rstInS)
	); // see R18

	rbws_sync #(.W(1), .RST_VAL(1'b1)) uSyncPll (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn(pllDisableStrap),
		.syncOut(pllS)
	);

	rbws_sync #(.W(1), .RST_VAL(1'b0)) uSyncMm (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn(memoryMapSelectStrap),
		.syncOut(mmS)
	);

	rbws_sync #(.W(1), .RST_VAL(1'b1)) uSyncNmi (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn(nonmaskableInterruptPinN),
		.syncOut(nmiNS)
	);

	rbws_sync #(.W(1), .RST_VAL(1'b0)) uSyncIrq (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn(wakeIrq),
		.syncOut(wakeIrqS)
	);

	rbws_sync #(.W(1), .RST_VAL(1'b0)) uSyncWd (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn(watchdogInterrupt),
		.syncOut(wdIntS)
	);

	rbws_sync #(.W(BOOT_W), .RST_VAL('0)) uSyncBoot (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn(bootModePins),
		.syncOut(bootS)
	);

	////////////////////////////////////////////////////////////////////////
	// Derived terms.

	// One system-clock cycle is one input cycle with the PLL off, else two.
	assign sysEn = s_r.pllOff | s_r.phase; // see R16
	// Any wake source; reset wakes through the reset path itself.
	assign wakeAny = wakeIrqS | wdIntS | ~nmiNS; // see R14
	// Qualification time in system cycles.
	assign qualTarget = 12'(QUAL_MUL * 12'(s_r.qualifier_period) * QUAL_FACTOR); // see R11
	// Resume latency depends on whether the flash must wake first.
	assign resumeTarget = s_r.flashSleep ? RESUME_SLEEP_CYC : RESUME_ACTIVE_CYC; // see R12 see R13
	// Half period of the output clock in system cycles; a divide of one is clamped to two.
	assign halfLimit = (s_r.timDiv & s_r.outDiv) ? 2'h2 : 2'h1; // see R9
	// Bus requests are answered one cycle after they appear.
	assign busReq = avsRead | avsWrite;
	assign wrDone = avsWrite & s_r.ack;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb begin
		s_nxt = s_r;
		s_nxt.phase = ~s_r.phase;
		s_nxt.bootPulse = 1'b0;
		s_nxt.resumePulse = 1'b0;
		s_nxt.ack = busReq & ~s_r.ack;

		// Watchdog reset pulse, counted on the input clock.
		if (watchdogTrigger) begin
			s_nxt.wdCnt = WD_RESET_CYC; // see R1
		end else if (s_r.wdCnt != 10'h000) begin
			s_nxt.wdCnt = s_r.wdCnt - 10'h001; // see R1 see R17
		end

		// Register writes take effect one edge after the wait ends.
		if (wrDone) begin
			unique case (avsAddress)
				OFS_CTRL: begin
					if (avsByteenable[0]) begin
						s_nxt.qualEn = avsWritedata[CTRL_QUALEN_BIT];
						s_nxt.flashSleep = avsWritedata[CTRL_FLASHSLP_BIT];
					end
					if (avsByteenable[1]) begin
						s_nxt.qualifier_period = avsWritedata[CTRL_QUALIFIER_PERIOD_LSB +: 8];
					end
				end
				OFS_EXTCFG: begin
					if (avsByteenable[0]) begin
						s_nxt.timDiv = avsWritedata[EXTCFG_TIMDIV_BIT];
						s_nxt.outDiv = avsWritedata[EXTCFG_OUTDIV_BIT];
					end
				end
				default: begin
				end
			endcase
		end

		// Output clock divider running on system-clock cycles.
		if (sysEn) begin
			if (s_r.clkCnt + 2'h1 >= halfLimit) begin
				s_nxt.clkCnt = 2'h0;
				s_nxt.clkOut = ~s_r.clkOut;
			end else begin
				s_nxt.clkCnt = s_r.clkCnt + 2'h1;
			end
		end

		// Reset input held low restarts the whole sequence.
		if (!rstInS) begin
			s_nxt.st = ST_RESET; // see R18
			s_nxt.seqCnt = 12'h000;
			s_nxt.exCnt = 6'h00;
			s_nxt.extValid = 1'b0;
			s_nxt.bootDone = 1'b0;
			s_nxt.timDiv = EXTCFG_DIV_RST; // see R9
			s_nxt.outDiv = EXTCFG_DIV_RST; // see R9
		end else begin
			// Address and data valid a fixed count after release.
			if (s_r.st != ST_RESET && !s_r.extValid) begin
				if (s_r.exCnt == EXT_VALID_CYC - 6'h01) begin
					s_nxt.extValid = 1'b1; // see R4
				end else begin
					s_nxt.exCnt = s_r.exCnt + 6'h01; // see R17
				end
			end
			unique case (s_r.st)
				ST_RESET: begin
					// First cycle after the synchronised release edge.
					s_nxt.st = ST_BOOT;
					s_nxt.pllOff = ~pllS; // see R5 see R16
					s_nxt.memMap = mmS; // see R6
					s_nxt.seqCnt = 12'h000;
				end
				ST_BOOT: begin
					if (sysEn) begin
						if (s_r.seqCnt == BOOT_SYS_CYC - 12'h001) begin
							s_nxt.bootMode = bootS; // see R8 see R7
							s_nxt.bootDone = 1'b1;
							s_nxt.bootPulse = 1'b1;
							s_nxt.seqCnt = 12'h000;
							s_nxt.st = ST_RUN;
						end else begin
							s_nxt.seqCnt = s_r.seqCnt + 12'h001; // see R8 see R17
						end
					end
				end
				ST_RUN: begin
					if (wrDone && avsAddress == OFS_CTRL && avsByteenable[0] && avsWritedata[CTRL_IDLE_BIT]) begin
						s_nxt.st = ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (wakeAny) begin
						s_nxt.seqCnt = 12'h000;
						s_nxt.st = (s_r.qualEn && qualTarget != 12'h000) ? ST_QUAL : ST_RESUME; // see R10
					end
				end
				ST_QUAL: begin
					// A wake that drops before the qualification time is discarded.
					if (!wakeAny) begin
						s_nxt.st = ST_IDLE; // see R10
					end else if (sysEn) begin
						if (s_r.seqCnt == qualTarget - 12'h001) begin
							s_nxt.seqCnt = 12'h000;
							s_nxt.st = ST_RESUME; // see R11
						end else begin
							s_nxt.seqCnt = s_r.seqCnt + 12'h001; // see R17
						end
					end
				end
				ST_RESUME: begin
					if (sysEn) begin
						if (s_r.seqCnt == resumeTarget - 12'h001) begin
							s_nxt.resumePulse = 1'b1; // see R15
							s_nxt.seqCnt = 12'h000;
							s_nxt.st = ST_RUN;
						end else begin
							s_nxt.seqCnt = s_r.seqCnt + 12'h001; // see R12 see R13
						end
					end
				end
			endcase
		end

		// Read data is built while the wait is asserted.
		s_nxt.rdata = 32'h0000_0000;
		if (avsRead && !s_r.ack) begin
			unique case (avsAddress)
				OFS_CTRL: begin
					s_nxt.rdata[CTRL_QUALEN_BIT] = s_r.qualEn;
					s_nxt.rdata[CTRL_FLASHSLP_BIT] = s_r.flashSleep;
					s_nxt.rdata[CTRL_QUALIFIER_PERIOD_LSB +: 8] = s_r.qualifier_period;
				end
				OFS_EXTCFG: begin
					s_nxt.rdata[EXTCFG_TIMDIV_BIT] = s_r.timDiv;
					s_nxt.rdata[EXTCFG_OUTDIV_BIT] = s_r.outDiv;
				end
				OFS_STATUS: begin
					s_nxt.rdata[2:0] = s_r.st;
					s_nxt.rdata[4] = s_r.pllOff;
					s_nxt.rdata[5] = s_r.memMap;
					s_nxt.rdata[6] = s_r.extValid;
					s_nxt.rdata[7] = s_r.bootDone;
					s_nxt.rdata[8 +: BOOT_W] = s_r.bootMode;
					s_nxt.rdata[12] = (s_r.wdCnt != 10'h000);
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_r <= RBWS_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	// Bus handshake.
	assign avsWaitrequest = busReq & ~s_r.ack;
	assign avsReaddata = s_r.rdata;
	// The reset pin is only ever pulled low.
	assign resetOut = 1'b0;
	assign resetOe = (s_r.wdCnt != 10'h000); // see R1
	// Sequencer results.
	assign coreClockDirect = s_r.pllOff; // see R16
	assign memoryMapSelect = s_r.memMap;
	assign extBusValid = s_r.extValid; // see R4
	assign bootSample = s_r.bootPulse;
	assign bootMode = s_r.bootMode;
	assign bootDone = s_r.bootDone;
	assign idleActive = (s_r.st == ST_IDLE) | (s_r.st == ST_QUAL) | (s_r.st == ST_RESUME);
	assign idleResume = s_r.resumePulse;
	assign clockOutPin = s_r.clkOut;

endmodule // rbws_sequencer
`default_nettype wire

// [verif/rbws_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module rbws_checker (
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Watched ports.
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic avsWaitrequest,
	input wire logic resetInN,
	input wire logic resetOe,
	input wire logic pllDisableStrap,
	input wire logic memoryMapSelectStrap,
	input wire logic watchdogTrigger,
	input wire logic coreClockDirect,
	input wire logic memoryMapSelect,
	input wire logic extBusValid,
	input wire logic bootSample,
	input wire logic bootDone,
	input wire logic idleActive,
	input wire logic idleResume
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [9:0] oeCnt;
	logic [11:0] relCnt;
	////////////////////////////////////////////////////////////////////////////////
	// Count cycles of the pulled reset and cycles since the reset line rose.
	always_ff @(posedge mclk) begin
		oeCnt <= (sys_rst || !resetOe) ? 10'h000 : oeCnt + 10'h001;
		relCnt <= (sys_rst || !resetInN) ? 12'h000 : relCnt + {11'h000, relCnt != 12'hfff};
	end
	// The release of the reset line and the bus becoming valid after it.
	sequence s_release;
		$rose(resetInN);
	endsequence
	sequence s_busValid;
		##[33:36] $rose(extBusValid);
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_wd_start: assert property (watchdogTrigger |=> resetOe)
		else $error("Watchdog pulse did not start.");
	a_wd_length: assert property ($fell(resetOe) |-> oeCnt == 10'h200)
		else $error("Watchdog pulse length is wrong.");
	a_bus_valid: assert property (s_release |-> s_busValid)
		else $error("Bus valid delay is wrong.");
	a_strap_latch: assert property (s_release |-> ##5 (coreClockDirect == !pllDisableStrap && memoryMapSelect == memoryMapSelectStrap))
		else $error("Straps were not latched.");
	a_boot_time: assert property (bootSample |-> (coreClockDirect ? relCnt inside {[1259:1267]} : relCnt inside {[2519:2527]}))
		else $error("Boot sampling time is wrong.");
	a_reset_clears: assert property ($fell(resetInN) |-> ##4 (!extBusValid && !bootDone && !idleActive))
		else $error("Reset did not clear the sequence.");
	a_bus_answer: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
		else $error("Bus answer is late.");
	a_resume_leaves: assert property (idleResume |-> $past(idleActive) && !idleActive)
		else $error("Resume did not leave idle.");
endmodule // rbws_checker
`default_nettype wire

// [verif/rbws_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module rbws_partner (
	// Clock and commands from the bench, and the reset pull-down enable from the device.
	input wire logic mclk,
	input wire logic rstReq,
	input wire logic [1:0] wakeSel,
	input wire logic [11:0] wakeLen,
	input wire logic [5:0] strapSel,
	input wire logic resetOe,
	// Pins towards the device.
	output logic resetInN,
	output logic pllDisableStrap,
	output logic memoryMapSelectStrap,
	output logic [3:0] bootModePins,
	output logic wakeIrq,
	output logic watchdogInterrupt,
	output logic nonmaskableInterruptPinN
);
	logic [4:0] lowCnt = 5'h1f;
	logic [11:0] relCnt = 12'h000;
	logic [11:0] wakeCnt = 12'h000;
	// Open-drain reset line with a pull-up; held low 20 cycles on a running clock.
	assign resetInN = (lowCnt == 5'h00) && !resetOe;
	// Straps keep their levels for the hold times, then show the inverse.
	assign pllDisableStrap = strapSel[0] ^ (relCnt > 12'h010);
	assign memoryMapSelectStrap = strapSel[1] ^ (relCnt > 12'h010);
	assign bootModePins = strapSel[5:2] ^ {4{relCnt > 12'h9d8}};
	// Wake pulse of the commanded length on the selected source.
	assign wakeIrq = (wakeCnt != 12'h000) && (wakeSel == 2'h1);
	assign watchdogInterrupt = (wakeCnt != 12'h000) && (wakeSel == 2'h2);
	assign nonmaskableInterruptPinN = !((wakeCnt != 12'h000) && (wakeSel == 2'h3));
	// Counters for reset hold, time since release and wake length.
	always_ff @(posedge mclk) begin
		lowCnt <= rstReq ? 5'h14 : lowCnt - {4'h0, lowCnt != 5'h00};
		relCnt <= !resetInN ? 12'h000 : relCnt + {11'h000, relCnt != 12'hfff};
		wakeCnt <= (wakeLen != 12'h000) ? wakeLen : wakeCnt - {11'h000, wakeCnt != 12'h000};
	end
endmodule // rbws_partner
`default_nettype wire

// [verif/tb_reset_boot_wake_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_reset_boot_wake_sequencer;
	import rbws_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] avsAddress = 4'h0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0000_0000;
	logic [31:0] avsReaddata;
	logic avsWaitrequest, resetInN, resetOe, pllDisableStrap, memoryMapSelectStrap, wakeIrq;
	logic watchdogInterrupt, nonmaskableInterruptPinN, coreClockDirect, memoryMapSelect, extBusValid;
	logic bootSample, bootDone, idleActive, idleResume, clockOutPin, resetOut;
	logic [3:0] avsByteenable = 4'hf;
	logic [3:0] bootModePins, bootMode;
	logic watchdogTrigger = 1'b0;
	logic rstReq = 1'b0;
	logic [1:0] wakeSel = 2'h1;
	logic [11:0] wakeLen = 12'h000;
	logic [5:0] strapSel = 6'h2a;
	logic [31:0] rd;
	int lat;
	int errCount = 0;
	int checksDone = 0;
	// Clock of 25 ns.
	always #12.5 mclk = ~mclk;
	rbws_sequencer dut (.*);
	rbws_partner partner (.*);
	////////////////////////////////////////////////////////////////////////////////
	// Compare, bus cycle, bounded wait and closing tasks.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		avsAddress <= a;
		avsWrite <= wr;
		avsRead <= !wr;
		avsWritedata <= wd;
		@(posedge mclk);
		while (avsWaitrequest !== 1'b0) @(posedge mclk);
		rd = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wait_for(ref logic s, input int lim);
		lat = 0;
		while (s !== 1'b1 && lat < lim) begin
			@(posedge mclk);
			lat++;
		end
	endtask
	task automatic finishTest;
		$display("Checks %0d errors %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Count rising edges of the output clock over 64 cycles.
	task automatic rises(input logic [31:0] exp);
		logic prev;
		logic [31:0] r;
		r = 32'h0000_0000;
		prev = clockOutPin;
		repeat (64) begin
			@(posedge mclk);
			r += {31'h0, clockOutPin === 1'b1 && prev === 1'b0};
			prev = clockOutPin;
		end
		check(r, exp);
	endtask
	// Reset through the partner with new straps, then check the boot outcome.
	task automatic reboot(input logic [5:0] sel, input logic [31:0] exp);
		strapSel <= sel;
		rstReq <= 1'b1;
		@(posedge mclk);
		rstReq <= 1'b0;
		repeat (40) @(posedge mclk);
		wait_for(bootDone, 3000);
		bus(1'b0, OFS_STATUS, 32'h0000_0000);
		check(rd, {20'h0_0000, sel[5:2], 2'b11, sel[1], !sel[0], 4'h2});
		rises(exp);
	endtask
	// Enter idle, send a wake pulse and measure the resume latency.
	task automatic idle(input logic [31:0] ctl, input logic [1:0] sel, input logic [11:0] len, input int lo);
		bus(1'b1, OFS_CTRL, ctl);
		check(idleActive, 32'h0000_0001);
		wakeSel <= sel;
		wakeLen <= len;
		@(posedge mclk);
		wakeLen <= 12'h000;
		wait_for(idleResume, lo + 60);
		check(lo ? (lat >= lo && lat <= lo + 8) : (lat == 60 && idleActive), 32'h0000_0001);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		bus(1'b0, OFS_EXTCFG, 32'h0000_0000);
		check(rd, 32'h0000_0003);
		bus(1'b0, 4'hc, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		reboot(6'h2a, 32'h0000_0010);
		bus(1'b1, OFS_STATUS, 32'hffff_ffff);
		bus(1'b0, OFS_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0af2);
		bus(1'b1, OFS_EXTCFG, 32'h0000_0000);
		rises(32'h0000_0020);
		bus(1'b1, OFS_EXTCFG, 32'h0000_0003);
		idle(32'h0000_0001, 2'h1, 12'h002, 8);
		idle(32'h0000_0001, 2'h2, 12'h002, 8);
		idle(32'h0000_0001, 2'h3, 12'h002, 8);
		idle(32'h0000_0005, 2'h1, 12'h002, 1050);
		idle(32'h0000_0103, 2'h1, 12'h004, 0);
		idle(32'h0000_0103, 2'h1, 12'h010, 18);
		// Only the low lane is written, so the qualifier period must keep its value.
		avsByteenable <= 4'h1;
		bus(1'b1, OFS_CTRL, 32'h0000_ff04);
		avsByteenable <= 4'hf;
		bus(1'b0, OFS_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0104);
		reboot(6'h17, 32'h0000_0008);
		watchdogTrigger <= 1'b1;
		@(posedge mclk);
		watchdogTrigger <= 1'b0;
		repeat (10) @(posedge mclk);
		check({resetOe, resetOut, bootDone}, 32'h0000_0004);
		repeat (600) @(posedge mclk);
		wait_for(bootDone, 3000);
		check({extBusValid, bootDone, bootMode}, 32'h0000_0035);
		finishTest;
	end
	// Hang guard.
	initial begin
		repeat (30000) @(posedge mclk);
		errCount++;
		finishTest;
	end
endmodule // tb_reset_boot_wake_sequencer
bind rbws_sequencer rbws_checker chk (
	.mclk(mclk), .sys_rst(sys_rst), .avsRead(avsRead), .avsWrite(avsWrite),
	.avsWaitrequest(avsWaitrequest), .resetInN(resetInN), .resetOe(resetOe),
	.pllDisableStrap(pllDisableStrap), .memoryMapSelectStrap(memoryMapSelectStrap),
	.watchdogTrigger(watchdogTrigger), .coreClockDirect(coreClockDirect), .memoryMapSelect(memoryMapSelect),
	.extBusValid(extBusValid), .bootSample(bootSample), .bootDone(bootDone), .idleActive(idleActive),
	.idleResume(idleResume)
);
`default_nettype wire
